// File: hw/aomfc_consts.svh
// constants of the output mode, format and encode timing control
// Notes on behaviour
// - mode strap: ground full CMOS, third demux CMOS, two thirds low LVDS, full LVDS.
// - format strap at ground or third gives offset binary, else two's complement.
// - stabilizer on only for format strap at one third or two thirds.
// - stabilizer samples on encode rise, makes its own fall at half period.
// - after a long stop, 100 encode cycles to relock; output invalid meanwhile.
// - gain strap low gives 2.25 V range, high gives 1.5 V range.
// - demux CMOS: output clocks at half encode rate, both buses valid together.
// - full-rate CMOS drives only the first bus, one sample per encode cycle.
`ifndef AOMFC_CONSTS_SVH
`define AOMFC_CONSTS_SVH

// ***********************************************************
// register map, byte addresses
// ***********************************************************
`define AOMFC_ADR_W         8
`define AOMFC_ADR_CTRL      8'h00
`define AOMFC_ADR_STATUS    8'h04
`define AOMFC_ADR_COUNT     8'h08
`define AOMFC_CTRL_OUT_EN   0
`define AOMFC_CTRL_RST      1'b1
`define AOMFC_ST_MODE       0
`define AOMFC_ST_TWOS       2
`define AOMFC_ST_STAB       3
`define AOMFC_ST_LOCKED     4
`define AOMFC_ST_GAIN       5
`define AOMFC_ST_VALID      6

// ***********************************************************
// four-level strap readings
// ***********************************************************
`define AOMFC_LVL_GND       2'b00
`define AOMFC_LVL_THIRD     2'b01
`define AOMFC_LVL_TWO_THIRD 2'b10
`define AOMFC_LVL_SUPPLY    2'b11

// ***********************************************************
// timing
// ***********************************************************
`define AOMFC_CLK_PERIOD_NS 50
`define AOMFC_MIN_ENC_PERIOD_NS 1000
`define AOMFC_STOP_CYC (`AOMFC_MIN_ENC_PERIOD_NS / `AOMFC_CLK_PERIOD_NS)
`define AOMFC_RELOCK_EDGES  100

`endif

// File: hw/aomfc_pkg.sv
// types shared by the output mode and format control
package aomfc_pkg;

  // output interface chosen by the mode strap
  typedef enum logic [1:0] {
    AOMFC_FULL_CMOS  = 2'b00,
    AOMFC_DEMUX_CMOS = 2'b01,
    AOMFC_LP_LVDS    = 2'b10,
    AOMFC_STD_LVDS   = 2'b11
  } aomfc_out_mode_t;

  // strap levels caught after reset
  typedef struct packed {
    aomfc_out_mode_t mode;
    logic [1:0]      fmt_lvl;
    logic            gain;
  } aomfc_straps_t;

  // one converted sample and its strobe
  typedef struct packed {
    logic [15:0] code;
    logic        stb;
  } aomfc_sample_t;

endpackage : aomfc_pkg

// File: hw/aomfc_fmt.sv
// sample number format stage
`timescale 1ns/1ps
`default_nettype none
module aomfc_fmt
  import aomfc_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          load_i,
  input  wire logic          twos_i,
  input  wire logic [15:0]   code_i,
  output aomfc_sample_t      smp_o
);

  aomfc_sample_t smp;
  aomfc_sample_t next_smp;

  // only the top bit differs between the two formats
  always_comb begin
    next_smp = smp;
    next_smp.stb = load_i;
    if (load_i) begin
      next_smp.code = {code_i[15] ^ twos_i, code_i[14:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      smp <= '0;
    end else begin
      smp <= next_smp;
    end
  end

  assign smp_o = smp;

  property p_fmt_msb;
    @(posedge clk_i) disable iff (!rst_b_i)
    load_i |=> smp.code[15] == ($past(code_i[15]) ^ $past(twos_i));
  endproperty
  a_fmt_msb: assert property (p_fmt_msb) else $error("top bit format wrong");

  property p_fmt_rest;
    @(posedge clk_i) disable iff (!rst_b_i)
    load_i |=> smp.stb && smp.code[14:0] == $past(code_i[14:0]);
  endproperty
  a_fmt_rest: assert property (p_fmt_rest) else $error("low bits altered");

endmodule : aomfc_fmt
`default_nettype wire

// File: hw/aomfc_stab.sv
// duty-cycle stabilizer: period tracker, internal fall and relock
`timescale 1ns/1ps
`default_nettype none
`include "aomfc_consts.svh"
module aomfc_stab
  import aomfc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic enable_i,
  input  wire logic rise_i,
  input  wire logic enc_level_i,
  output logic      int_clk_o,
  output logic      locked_o
);

  localparam logic [7:0] STOP = 8'(`AOMFC_STOP_CYC);
  localparam logic [6:0] LAST = 7'(`AOMFC_RELOCK_EDGES - 1);

  logic [7:0] cnt, next_cnt, period, next_period;
  logic [6:0] lock_cnt, next_lock_cnt;
  logic       next_int, next_locked;

  // cnt saturates: a quiet encode for a whole slowest period means stopped
  always_comb begin
    next_cnt      = cnt;
    next_period   = period;
    next_lock_cnt = lock_cnt;
    next_int      = int_clk_o;
    next_locked   = locked_o;
    if (rise_i) begin
      next_period = cnt + 8'd1;
      next_cnt    = 8'd0;
    end else if (cnt != STOP) begin
      next_cnt = cnt + 8'd1;
    end
    if (!enable_i) begin
      next_int      = enc_level_i;
      next_locked   = 1'b1;
      next_lock_cnt = 7'd0;
    end else begin
      if (rise_i) begin
        next_int = 1'b1;
      end else if (cnt == STOP || (cnt + 8'd1) == {1'b0, period[7:1]}) begin
        next_int = 1'b0;
      end
      // a rise after the stop is the first of the hundred, not a stop cycle
      if (cnt == STOP && !rise_i) begin
        next_locked   = 1'b0;
        next_lock_cnt = 7'd0;
      end else if (rise_i && !locked_o) begin
        if (lock_cnt == LAST) begin
          next_locked = 1'b1;
        end else begin
          next_lock_cnt = lock_cnt + 7'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt       <= 8'h00;
      period    <= 8'h00;
      lock_cnt  <= 7'h00;
      int_clk_o <= 1'b0;
      locked_o  <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      period    <= next_period;
      lock_cnt  <= next_lock_cnt;
      int_clk_o <= next_int;
      locked_o  <= next_locked;
    end
  end

  property p_stab_rise;
    @(posedge clk_i) disable iff (!rst_b_i)
    enable_i && rise_i |=> int_clk_o;
  endproperty
  a_stab_rise: assert property (p_stab_rise) else $error("no internal rise");

  property p_stab_relock;
    @(posedge clk_i) disable iff (!rst_b_i)
    enable_i && $rose(locked_o) |-> $past(lock_cnt) == LAST && $past(rise_i);
  endproperty
  a_stab_relock: assert property (p_stab_relock) else $error("early relock");

  property p_stab_stop;
    @(posedge clk_i) disable iff (!rst_b_i)
    enable_i && cnt == STOP && !rise_i |=> !locked_o && !int_clk_o;
  endproperty
  a_stab_stop: assert property (p_stab_stop) else $error("lock kept on stop");

endmodule : aomfc_stab
`default_nettype wire

// File: hw/aomfc_top.sv
// output mode, sample format and encode control with wishbone registers
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "aomfc_consts.svh"
module aomfc_top
  import aomfc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`AOMFC_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [1:0]              output_mode_sel_i,
  input  wire logic [1:0]              format_sel_i,
  input  wire logic                    gain_range_select_i,
  input  wire logic                    encode_clock_i,
  input  wire logic [15:0]             core_code_i,
  output logic      [15:0]             data_a_o,
  output logic      [15:0]             data_b_o,
  output logic                         output_clock_first_o,
  output logic                         output_clock_second_o,
  output logic                         data_valid_o,
  output logic                         internal_clock_o,
  output logic                         gain_range_o,
  output logic                         lvds_mode_o,
  output logic                         lvds_low_power_o,
  output logic                         demux_o
);

  // ***********************************************************
  // strap capture
  // ***********************************************************
  aomfc_straps_t straps, next_straps;
  logic          strap_valid, next_strap_valid;
  logic          stab_en, twos;

  // straps are caught on the first clean edge after reset release
  always_comb begin
    next_straps      = straps;
    next_strap_valid = 1'b1;
    if (!strap_valid) begin
      next_straps.mode    = aomfc_out_mode_t'(output_mode_sel_i);
      next_straps.fmt_lvl = format_sel_i;
      next_straps.gain    = gain_range_select_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      straps      <= '0;
      strap_valid <= 1'b0;
    end else begin
      straps      <= next_straps;
      strap_valid <= next_strap_valid;
    end
  end

  // format and stabilizer follow the same four-level strap
  assign twos    = straps.fmt_lvl[1];
  assign stab_en = straps.fmt_lvl == `AOMFC_LVL_THIRD ||
                   straps.fmt_lvl == `AOMFC_LVL_TWO_THIRD;

  // ***********************************************************
  // encode edge and stabilizer
  // ***********************************************************
  logic enc_q, next_enc_q, int_q, next_int_q;
  logic enc_rise, int_fall, locked, stab_rst_b;

  // encode pin is taken as synchronous, so one flop is enough for edges
  always_comb begin
    next_enc_q = encode_clock_i;
    next_int_q = internal_clock_o;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      enc_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      enc_q <= next_enc_q;
      int_q <= next_int_q;
    end
  end

  assign enc_rise = encode_clock_i && !enc_q && strap_valid;
  assign int_fall = int_q && !internal_clock_o;

  // stabilizer waits for the straps, else it locks on the reset strap value
  assign stab_rst_b = rst_b_i && strap_valid;

  aomfc_stab u_stab (
    .clk_i       (clk_i),
    .rst_b_i     (stab_rst_b),
    .enable_i    (stab_en),
    .rise_i      (enc_rise),
    .enc_level_i (encode_clock_i),
    .int_clk_o   (internal_clock_o),
    .locked_o    (locked)
  );

  aomfc_sample_t conv;

  aomfc_fmt u_fmt (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .load_i  (enc_rise),
    .twos_i  (twos),
    .code_i  (core_code_i),
    .smp_o   (conv)
  );

  // ***********************************************************
  // wishbone slave
  // ***********************************************************
  logic        out_en, next_out_en, next_ack;
  logic [31:0] next_dat, status;
  logic [15:0] smp_cnt, next_smp_cnt;
  logic        wr_take;

  // a write lands at the edge where the master sees ack high
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_comb begin
    status = 32'h0;
    status[`AOMFC_ST_MODE +: 2] = straps.mode;
    status[`AOMFC_ST_TWOS]      = twos;
    status[`AOMFC_ST_STAB]      = stab_en;
    status[`AOMFC_ST_LOCKED]    = locked;
    status[`AOMFC_ST_GAIN]      = straps.gain;
    status[`AOMFC_ST_VALID]     = strap_valid;
  end

  // single-wait answer; unmapped words read zero and ignore writes
  always_comb begin
    next_ack     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat     = 32'h0;
    next_out_en  = out_en;
    next_smp_cnt = smp_cnt;
    if (conv.stb) begin
      next_smp_cnt = smp_cnt + 16'd1;
    end
    if (wb_adr_i == `AOMFC_ADR_CTRL) begin
      next_dat[`AOMFC_CTRL_OUT_EN] = out_en;
    end else if (wb_adr_i == `AOMFC_ADR_STATUS) begin
      next_dat = status;
    end else if (wb_adr_i == `AOMFC_ADR_COUNT) begin
      next_dat = {16'h0, smp_cnt};
    end
    if (wr_take && wb_sel_i[0] && wb_adr_i == `AOMFC_ADR_CTRL) begin
      next_out_en = wb_dat_i[`AOMFC_CTRL_OUT_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      out_en   <= `AOMFC_CTRL_RST;
      smp_cnt  <= 16'h0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_ack ? next_dat : 32'h0;
      out_en   <= next_out_en;
      smp_cnt  <= next_smp_cnt;
    end
  end

  // ***********************************************************
  // output buses and output clocks
  // ***********************************************************
  logic        demux, phase, next_phase, next_ck;
  logic [15:0] pend, next_pend, next_a, next_b;

  assign demux = straps.mode == AOMFC_DEMUX_CMOS;

  // demux: first sample waits, second lands with it; clocks toggle per sample
  always_comb begin
    next_a     = data_a_o;
    next_b     = data_b_o;
    next_pend  = pend;
    next_phase = phase;
    next_ck    = output_clock_first_o;
    if (conv.stb && out_en) begin
      if (demux) begin
        if (!phase) begin
          next_pend  = conv.code;
          next_ck    = 1'b1;
          next_phase = 1'b1;
        end else begin
          next_a     = pend;
          next_b     = conv.code;
          next_ck    = 1'b0;
          next_phase = 1'b0;
        end
      end else begin
        next_a  = conv.code;
        next_ck = 1'b0;
      end
    end else if (!demux && int_fall) begin
      next_ck = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_a_o              <= 16'h0;
      data_b_o              <= 16'h0;
      pend                  <= 16'h0;
      phase                 <= 1'b0;
      output_clock_first_o  <= 1'b0;
      output_clock_second_o <= 1'b1;
    end else begin
      data_a_o              <= next_a;
      data_b_o              <= next_b;
      pend                  <= next_pend;
      phase                 <= next_phase;
      output_clock_first_o  <= next_ck;
      output_clock_second_o <= !next_ck;
    end
  end

  // ***********************************************************
  // mode, gain and validity flags
  // ***********************************************************
  logic next_valid;

  // nothing is valid until straps are known and the loop has relocked
  always_comb begin
    next_valid = strap_valid && out_en && locked;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_valid_o     <= 1'b0;
      gain_range_o     <= 1'b0;
      lvds_mode_o      <= 1'b0;
      lvds_low_power_o <= 1'b0;
      demux_o          <= 1'b0;
    end else begin
      data_valid_o     <= next_valid;
      gain_range_o     <= straps.gain;
      lvds_mode_o      <= straps.mode[1];
      lvds_low_power_o <= straps.mode == AOMFC_LP_LVDS;
      demux_o          <= demux;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_mode_pins;
    @(posedge clk_i) disable iff (!rst_b_i)
    strap_valid && $past(strap_valid) |->
      lvds_mode_o == straps.mode[1] &&
      lvds_low_power_o == (straps.mode == AOMFC_LP_LVDS) &&
      demux_o == (straps.mode == AOMFC_DEMUX_CMOS);
  endproperty
  a_mode_pins: assert property (p_mode_pins) else $error("mode pins wrong");

  property p_stab_sel;
    @(posedge clk_i) disable iff (!rst_b_i)
    strap_valid |-> stab_en == (straps.fmt_lvl inside {2'b01, 2'b10}) &&
      twos == (straps.fmt_lvl inside {2'b10, 2'b11});
  endproperty
  a_stab_sel: assert property (p_stab_sel) else $error("format decode wrong");

  property p_gain;
    @(posedge clk_i) disable iff (!rst_b_i)
    strap_valid |=> gain_range_o == $past(straps.gain);
  endproperty
  a_gain: assert property (p_gain) else $error("gain range wrong");

  sequence s_pair_close;
    demux && phase && conv.stb && out_en;
  endsequence

  sequence s_pair_out;
    !output_clock_first_o && output_clock_second_o;
  endsequence

  property p_demux_pair;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_pair_close |=> s_pair_out ##0 data_b_o == $past(conv.code) &&
      data_a_o == $past(pend);
  endproperty
  a_demux_pair: assert property (p_demux_pair) else $error("demux pair wrong");

  property p_full_rate;
    @(posedge clk_i) disable iff (!rst_b_i)
    !demux && conv.stb && out_en |=> data_a_o == $past(conv.code) &&
      data_b_o == 16'h0 && !output_clock_first_o;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate bus wrong");

  property p_valid;
    @(posedge clk_i) disable iff (!rst_b_i)
    data_valid_o |-> $past(locked) && $past(strap_valid);
  endproperty
  a_valid: assert property (p_valid) else $error("valid while unlocked");

endmodule : aomfc_top
`default_nettype wire

// File: tb/aomfc_far_end.sv
// encode clock source and capture logic standing at the far side of the sample path
`timescale 1ns/1ps
`default_nettype none
module aomfc_far_end
(
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic        hold_i,
  input  wire logic [3:0]  hi_i,
  input  wire logic [3:0]  lo_i,
  input  wire logic        first_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] data_a_i,
  input  wire logic [15:0] data_b_i,
  output logic             encode_o,
  output logic      [15:0] code_o,
  output int               n_rise_o,
  output int               n_cap_o,
  output logic      [15:0] cap_a_o,
  output logic      [15:0] cap_b_o
);
  logic [3:0] ph = 4'h0;
  logic       first_q = 1'b0;

  initial begin
    encode_o = 1'b0;
    code_o = 16'h7ff8;
    n_rise_o = 0;
    n_cap_o = 0;
    cap_a_o = 16'h0;
    cap_b_o = 16'h0;
  end

  // encode phase counter; high and low spans in clk cycles come from the bench
  always @(posedge clk_i) begin
    if (!run_i) begin
      encode_o <= 1'b0;  // clock stands still while stopped
      ph <= 4'h0;
    end else if (ph + 4'h1 < (encode_o ? hi_i : lo_i)) begin
      ph <= ph + 4'h1;
    end else begin
      ph <= 4'h0;
      encode_o <= ~encode_o;
      if (!encode_o) begin
        n_rise_o <= n_rise_o + 1;
        code_o <= hold_i ? code_o : code_o + 16'h0001;
      end
    end
  end

  // latch both buses on the first output clock rise; invalid output is dropped
  always @(posedge clk_i) begin
    first_q <= first_i;
    if (first_i && !first_q && valid_i) begin
      cap_a_o <= data_a_i;
      cap_b_o <= data_b_i;
      n_cap_o <= n_cap_o + 1;
    end
  end
endmodule  // aomfc_far_end
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the output mode, format and encode control
`timescale 1ns/1ps
`default_nettype none
`include "aomfc_consts.svh"
module tb
  import aomfc_pkg::*;
;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] fmt;
    logic       gain;
    logic [4:0] flags;  // lvds, low power, demux, twos, stabilizer
  } aomfc_row_t;

  aomfc_row_t rows [5] = '{
    '{2'b00, 2'b00, 1'b0, 5'b00000},
    '{2'b01, 2'b01, 1'b1, 5'b00101},
    '{2'b10, 2'b10, 1'b0, 5'b11011},
    '{2'b11, 2'b11, 1'b1, 5'b10010},
    '{2'b01, 2'b10, 1'b0, 5'b00111}
  };

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [1:0]  mode_sel = 2'b00;
  logic [1:0]  fmt_sel = 2'b00;
  logic        gain_sel = 1'b0;
  logic        run = 1'b1;
  logic        hold = 1'b1;
  logic [3:0]  hi = 4'h4;
  logic [3:0]  lo = 4'h4;
  logic [31:0] rdat;
  logic        ack;
  logic [15:0] data_a;
  logic [15:0] data_b;
  logic        ck1;
  logic        ck2;
  logic        valid;
  logic        int_clk;
  logic        gain_r;
  logic        lvds;
  logic        lvds_lp;
  logic        demux;
  logic        encode;
  logic [15:0] code;
  logic [15:0] cap_a;
  logic [15:0] cap_b;
  int          n_rise;
  int          n_cap;
  int          n_errors = 0;
  int          cmp_count = 0;

  always #25 clk = ~clk;

  aomfc_top u_aomfc_top (.clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .output_mode_sel_i(mode_sel), .format_sel_i(fmt_sel),
    .gain_range_select_i(gain_sel), .encode_clock_i(encode), .core_code_i(code),
    .data_a_o(data_a), .data_b_o(data_b), .output_clock_first_o(ck1),
    .output_clock_second_o(ck2), .data_valid_o(valid), .internal_clock_o(int_clk),
    .gain_range_o(gain_r), .lvds_mode_o(lvds), .lvds_low_power_o(lvds_lp), .demux_o(demux));

  aomfc_far_end u_aomfc_far_end (.clk_i(clk), .run_i(run), .hold_i(hold), .hi_i(hi),
    .lo_i(lo), .first_i(ck1), .valid_i(valid), .data_a_i(data_a), .data_b_i(data_b),
    .encode_o(encode), .code_o(code), .n_rise_o(n_rise), .n_cap_o(n_cap),
    .cap_a_o(cap_a), .cap_b_o(cap_b));

  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic err(input string msg);
    n_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) err(msg);
  endtask

  // bounded wait on encode rises or on captures of the far end
  task automatic wait_for(input int n, input logic caps);
    int t;
    int g;
    t = (caps ? n_cap : n_rise) + n;
    g = 0;
    while ((caps ? n_cap : n_rise) < t && g < 4000) begin
      @(posedge clk);
      g++;
    end
    if (g >= 4000) err("wait ran out");
  endtask

  // classic cycle: held until ack is seen high, released after that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 30);
    if (n >= 30) err("bus answer missing");
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'({data_a, ck2, valid}), 32'h2, "reset outputs");
    rst_b <= 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ***********************************************************
  // strap table, then bus, relock and output enable
  // ***********************************************************
  initial begin
    aomfc_row_t  r;
    logic [31:0] rd;
    logic [31:0] st;
    logic [15:0] f;
    logic [15:0] a0;
    logic [15:0] b0;
    int          hc;
    int          c0;
    int          k0;
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      mode_sel <= r.mode;
      fmt_sel <= r.fmt;
      gain_sel <= r.gain;
      hi <= r.flags[0] ? 4'h3 : 4'h4;
      lo <= r.flags[0] ? 4'h5 : 4'h4;
      do_reset();
      wait_for(110, 1'b0);
      f = {r.flags[1], 15'h0};
      chk(32'({lvds, lvds_lp, demux, gain_r}), 32'({r.flags[4:2], r.gain}), "flags");
      wb(1'b0, `AOMFC_ADR_STATUS, 4'hf, 32'h0, rd);
      chk(rd, {25'h0, 1'b1, r.gain, 1'b1, r.flags[0], r.flags[1], r.mode}, "status");
      chk(32'(data_a), 32'(code ^ f), "first bus");
      chk(32'(data_b), 32'(r.flags[2] ? code ^ f : 16'h0), "second bus");
      c0 = n_rise;
      k0 = n_cap;
      hc = 0;
      repeat (128) begin
        @(posedge clk);
        if (int_clk === 1'b1) hc++;
      end
      chk(32'(hc > 62 && hc < 66), 32'h1, "internal duty");
      c0 = (n_rise - c0) >> r.flags[2];
      k0 = n_cap - k0;
      chk(32'(k0 >= c0 - 1 && k0 <= c0 + 1), 32'h1, "output clock rate");
      $display("test strap row %0d done", i);
    end
    // last row is demux: earlier sample on the first bus, later on the second
    hold <= 1'b0;
    wait_for(3, 1'b1);
    a0 = cap_a;
    b0 = cap_b;
    wait_for(1, 1'b1);
    chk(32'(b0), 32'(a0 + 16'h1), "pair order");
    chk(32'(cap_a), 32'(b0 + 16'h1), "next pair");
    $display("test demux pairing done");
    wb(1'b0, `AOMFC_ADR_CTRL, 4'hf, 32'h0, rd);
    chk(rd, 32'h1, "ctrl reset value");
    wb(1'b1, 8'h0c, 4'hf, 32'hffffffff, rd);
    wb(1'b0, 8'h0c, 4'hf, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    wb(1'b0, `AOMFC_ADR_STATUS, 4'hf, 32'h0, st);
    wb(1'b1, `AOMFC_ADR_STATUS, 4'hf, 32'h0, rd);
    run <= 1'b0;
    repeat (30) @(posedge clk);
    wb(1'b0, `AOMFC_ADR_STATUS, 4'hf, 32'h0, rd);
    chk(rd, st & ~32'h10, "status while stopped");
    wb(1'b0, `AOMFC_ADR_COUNT, 4'hf, 32'h0, st);
    wb(1'b1, `AOMFC_ADR_COUNT, 4'hf, 32'h0, rd);
    wb(1'b0, `AOMFC_ADR_COUNT, 4'hf, 32'h0, rd);
    chk(rd, st, "count read only");
    wb(1'b1, `AOMFC_ADR_CTRL, 4'h0, 32'h0, rd);
    wb(1'b0, `AOMFC_ADR_CTRL, 4'hf, 32'h0, rd);
    chk(rd, 32'h1, "ctrl byte enable");
    $display("test register bus done");
    // restart after a long stop: output stays invalid for a hundred rises
    c0 = n_rise;
    run <= 1'b1;
    wait_for(99, 1'b0);
    repeat (3) @(posedge clk);
    chk(32'(valid), 32'h0, "valid before relock");
    wait_for(1, 1'b0);
    repeat (6) @(posedge clk);
    chk(32'(valid), 32'h1, "valid after relock");
    wb(1'b0, `AOMFC_ADR_COUNT, 4'hf, 32'h0, rd);
    k0 = n_rise - c0;
    chk(32'(rd - st <= k0 && rd - st + 1 >= k0), 32'h1, "sample count");
    $display("test relock done");
    wb(1'b1, `AOMFC_ADR_CTRL, 4'hf, 32'h0, rd);
    wait_for(2, 1'b0);
    a0 = data_a;
    wait_for(10, 1'b0);
    chk(32'({valid, data_a}), 32'({1'b0, a0}), "outputs frozen");
    wb(1'b1, `AOMFC_ADR_CTRL, 4'hf, 32'h1, rd);
    wait_for(4, 1'b0);
    chk(32'(valid), 32'h1, "outputs resumed");
    $display("test output enable done");
    tally_and_finish();
  end

  // hang guard, well above the six thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err("watchdog expired");
    tally_and_finish();
  end
endmodule  // tb
`default_nettype wire
